// ===== conv_front_model.sv
// Purpose: Converter front end answering each conversion request.
// Assumes: Result taken by the sequencer before the next request.
// Notes: Each sample of a remote slot is one code higher than the last.
`timescale 1ns/10ps
module conv_front_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request and per channel base codes
  input wire logic conv_start,
  input wire temp_monitor_pkg::chan_t conv_sel,
  input wire logic [7:0] base [0:8],
  // Answer
  output logic [9:0] conv_result
);
  logic [7:0] k_q;
  logic [3:0] sel_q;
  // Changing samples show whether all 16 are summed, not just one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      k_q <= 8'h00;
      sel_q <= 4'hF;
      conv_result <= 10'h3FF;
    end else if (conv_start) begin
      k_q <= (conv_sel == sel_q) ? k_q + 8'h01 : 8'h01;
      sel_q <= conv_sel;
      conv_result <= {base[conv_sel] + ((conv_sel == sel_q) ? k_q : 8'h00),
        2'b10};
    end
  end
endmodule

// ===== limit_check.sv
// Purpose: Limit comparison of one stored result.
// Assumes: Update strobe comes with the new value in the same cycle.
// Notes: Temperatures compare signed with hysteresis, voltages unsigned.
`timescale 1ns/10ps
module limit_check #(
  parameter bit IS_TEMP = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // New result
  input wire logic upd,
  input wire logic [7:0] value,
  // Limits
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  // Result
  output logic alarm,
  output logic set
);
  logic alarm_d;

  always_comb begin
    alarm_d = alarm;
    if (IS_TEMP) begin
      if ($signed(value) > $signed(hi)) begin
        alarm_d = 1'b1;
      end else if ($signed(value) <= $signed(lo)) begin
        alarm_d = 1'b0;
      end
    end else begin
      alarm_d = (value > hi) || (value < lo);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm <= 1'b0;
      set <= 1'b0;
    end else begin
      set <= upd && alarm_d;
      if (upd) begin
        alarm <= alarm_d;
      end
    end
  end
endmodule

// ===== slot_timer.sv
// Purpose: Down counter giving a one-cycle tick after a loaded length.
// Assumes: Length of at least one cycle.
// Notes: Repeat mode reloads itself until stopped.
`timescale 1ns/10ps
module slot_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic stop,
  input wire logic repeat_en,
  input wire logic [W-1:0] len,
  // Event
  output logic tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] len_q;
  logic busy_q;
  logic rep_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      len_q <= '0;
      busy_q <= 1'b0;
      rep_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (load) begin
        cnt_q <= len - W'(1);
        len_q <= len;
        rep_q <= repeat_en;
        busy_q <= 1'b1;
      end else if (stop) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          tick <= 1'b1;
          cnt_q <= len_q - W'(1);
          busy_q <= rep_q;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule

// ===== temp_monitor_consts.svh
// Purpose: Named constants of the monitor sequencer.
// Assumes: 200 MHz system clock.
// Notes: Register indices are word indices; byte address is four times.
`ifndef TEMP_MONITOR_CONSTS_SVH
`define TEMP_MONITOR_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////
`define CLK_MHZ 200
`define T_ANALOG_SLOT_US 755
`define T_TEMP_SLOT_US 33240
`define T_REMOTE_MEAS_US 9600
`define AVG_N 16
`define AVG_CNT_W 5
`define ACC_W 12

////////////////////////////////////////////////////////////////////////////
`define NUM_CH 9
`define CH_W 4
`define CH_AIN1 4'h0
`define CH_AIN2 4'h1
`define CH_VCC 4'h5
`define CH_REMOTE1 4'h6
`define CH_INT_TEMP 4'h7
`define CH_REMOTE2 4'h8

////////////////////////////////////////////////////////////////////////////
`define REG_VALUE_BASE 8'h20
`define REG_INT_TEMP 8'h27
`define REG_LIMIT_BASE 8'h2B
`define REG_CTRL 8'h40
`define REG_INT_STATUS 8'h41
`define REG_INT_MASK 8'h43
`define REG_FUNC_SEL 8'h47
`define REG_TEMP_FRAC 8'h4B

`define CTRL_START 0
`define CTRL_INT_EN 1
`define CTRL_INT_CLR 3
`define FUNC_AIN1 0
`define FUNC_AIN2 1
`define FUNC_REMOTE2 2
`define FRAC_LSB 6

`define CTRL_RST 8'h00
`define FUNC_RST 8'h00
`define FRCFG_RST 6'h00
`define VHI_RST 8'hFF
`define VLO_RST 8'h00
`define THI_RST 8'h7F
`define TLO_RST 8'h7F
`define VAL_RST 8'h00

`endif

// ===== temp_monitor_pkg.sv
// Purpose: Types shared by the monitor sequencer files.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are left to the tools.
package temp_monitor_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PICK,
    ST_CONV,
    ST_STORE
  } seq_state_e;
  typedef logic [3:0] chan_t;
  typedef logic [7:0] byte_t;
endpackage

// ===== temp_monitor_sequencer.sv
// Purpose: Round-robin conversion sequencer and result registers.
// Assumes: Converter front end answers on the same clock.
// Notes: Registers are word aligned; byte address is four times index.
`timescale 1ns/10ps
`include "temp_monitor_consts.svh"
module temp_monitor_sequencer #(
  parameter int unsigned ANALOG_SLOT_CYC = `T_ANALOG_SLOT_US * `CLK_MHZ,
  parameter int unsigned TEMP_SLOT_CYC = `T_TEMP_SLOT_US * `CLK_MHZ,
  parameter int unsigned SUB_CYC =
    `T_REMOTE_MEAS_US * `CLK_MHZ / `AVG_N,
  parameter int TW = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter front end
  output logic conv_start,
  output temp_monitor_pkg::chan_t conv_sel,
  input wire logic [9:0] conv_result,
  // Fan monitor
  output logic fan_mon_start,
  output logic fan_mon_run,
  // Interrupt
  output logic irq
);
  import temp_monitor_pkg::*;

  localparam int NCH = `NUM_CH;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [NCH-1:0] en_mask(input byte_t f);
    logic [NCH-1:0] m;
    m = '1;
    m[`CH_AIN1] = f[`FUNC_AIN1];
    m[`CH_AIN2] = f[`FUNC_AIN2];
    m[`CH_REMOTE1] = 1'b1;
    m[`CH_REMOTE2] = f[`FUNC_REMOTE2];
    return m;
  endfunction

  function automatic chan_t next_ch(input chan_t cur,
                                    input logic [NCH-1:0] en);
    chan_t r;
    int idx;
    r = cur;
    for (int i = NCH; i >= 1; i--) begin
      idx = (int'(cur) + i) % NCH;
      if (en[idx]) begin
        r = chan_t'(idx);
      end
    end
    return r;
  endfunction

  function automatic logic is_remote(input chan_t c);
    return (c == `CH_REMOTE1) || (c == `CH_REMOTE2);
  endfunction

  function automatic logic is_temp(input chan_t c);
    return is_remote(c) || (c == `CH_INT_TEMP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  seq_state_e state_q;
  chan_t ch_q;
  chan_t ch_nxt;
  byte_t ctrl_q;
  byte_t func_q;
  logic [5:0] frcfg_q;
  logic [1:0] frac_q;
  byte_t val_q [NCH];
  byte_t hi_q [NCH];
  byte_t lo_q [NCH];
  logic [9:0] raw_q;
  logic [`ACC_W-1:0] acc_q;
  logic [`AVG_CNT_W-1:0] nsamp_q;
  logic [NCH-1:0] status_q;
  logic [NCH-1:0] mask_q;
  logic [NCH-1:0] set_ev;
  logic [NCH-1:0] alarm_lvl;
  logic [NCH-1:0] en;
  logic run;
  logic store;
  logic slot_load;
  logic slot_done;
  logic sub_tick;
  logic sub_take;
  logic [TW-1:0] slot_len;
  byte_t result;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] idx;
  logic [31:0] rd_word;

  assign en = en_mask(func_q);
  assign run = ctrl_q[`CTRL_START] && !ctrl_q[`CTRL_INT_CLR];
  assign ch_nxt = next_ch(ch_q, en);
  assign slot_load = (state_q == ST_PICK) && run;
  assign store = (state_q == ST_STORE);
  assign sub_take = sub_tick && (nsamp_q != `AVG_CNT_W'(`AVG_N));
  assign slot_len = is_remote(ch_nxt) ? TW'(TEMP_SLOT_CYC)
                                      : TW'(ANALOG_SLOT_CYC);
  assign result = is_remote(ch_q) ? acc_q[`ACC_W-1:`ACC_W-8]
                                  : raw_q[9:2];
  assign wr_fire = avs_write && !avs_waitrequest;
  assign rd_fire = avs_read && avs_waitrequest;
  assign idx = avs_address[9:2];

  ////////////////////////////////////////////////////////////////////////
  slot_timer #(.W(TW)) u_slot (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(slot_load),
    .stop(1'b0),
    .repeat_en(1'b0),
    .len(slot_len),
    .tick(slot_done)
  );

  slot_timer #(.W(TW)) u_sub (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(slot_load && is_remote(ch_nxt)),
    .stop(store),
    .repeat_en(1'b1),
    .len(TW'(SUB_CYC)),
    .tick(sub_tick)
  );

  for (genvar g = 0; g < NCH; g++) begin : g_lim
    limit_check #(.IS_TEMP(is_temp(chan_t'(g)))) u_lim (
      .clk_sys(clk_sys),
      .rst(rst),
      .upd(store && (ch_q == chan_t'(g))),
      .value(result),
      .hi(hi_q[g]),
      .lo(lo_q[g]),
      .alarm(alarm_lvl[g]),
      .set(set_ev[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer. A cleared start bit lets the running slot finish and store.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ch_q <= chan_t'(`CH_REMOTE2);
      conv_start <= 1'b0;
      conv_sel <= '0;
      fan_mon_start <= 1'b0;
      fan_mon_run <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      fan_mon_start <= 1'b0;
      fan_mon_run <= run;
      case (state_q)
        ST_IDLE: begin
          if (run) begin
            fan_mon_start <= 1'b1;
            ch_q <= chan_t'(`CH_REMOTE2);
            state_q <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (!run) begin
            state_q <= ST_IDLE;
          end else begin
            ch_q <= ch_nxt;
            conv_sel <= ch_nxt;
            conv_start <= 1'b1;
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (sub_take && nsamp_q != `AVG_CNT_W'(`AVG_N - 1)) begin
            conv_start <= 1'b1;
          end
          if (slot_done) begin
            state_q <= ST_STORE;
          end
        end
        ST_STORE: begin
          state_q <= ST_PICK;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Sampling and averaging of converter results.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      raw_q <= '0;
      acc_q <= '0;
      nsamp_q <= '0;
    end else begin
      if (slot_load) begin
        acc_q <= '0;
        nsamp_q <= '0;
      end else if (state_q == ST_CONV) begin
        if (sub_take) begin
          acc_q <= acc_q + {{(`ACC_W-8){conv_result[9]}},
                            conv_result[9:2]};
          nsamp_q <= nsamp_q + `AVG_CNT_W'(1);
        end
        if (slot_done) begin
          raw_q <= conv_result;
        end
      end
    end
  end

  // Result registers, written once per slot before the next slot starts.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        val_q[i] <= `VAL_RST;
      end
      frac_q <= '0;
    end else if (store) begin
      val_q[ch_q] <= result;
      if (ch_q == `CH_INT_TEMP) begin
        frac_q <= raw_q[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RST;
      func_q <= `FUNC_RST;
      frcfg_q <= `FRCFG_RST;
      mask_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        hi_q[i] <= is_temp(chan_t'(i)) ? `THI_RST : `VHI_RST;
        lo_q[i] <= is_temp(chan_t'(i)) ? `TLO_RST : `VLO_RST;
      end
    end else if (wr_fire) begin
      if (avs_byteenable[0]) begin
        if (idx == `REG_CTRL) begin
          ctrl_q <= avs_writedata[7:0];
        end
        if (idx == `REG_FUNC_SEL) begin
          func_q <= avs_writedata[7:0];
        end
        if (idx == `REG_TEMP_FRAC) begin
          frcfg_q <= avs_writedata[`FRAC_LSB-1:0];
        end
        if (idx == `REG_INT_MASK) begin
          mask_q[7:0] <= avs_writedata[7:0];
        end
        for (int i = 0; i < NCH; i++) begin
          if (idx == `REG_LIMIT_BASE + 8'(2 * i)) begin
            hi_q[i] <= avs_writedata[7:0];
          end
          if (idx == `REG_LIMIT_BASE + 8'(2 * i + 1)) begin
            lo_q[i] <= avs_writedata[7:0];
          end
        end
      end
      if (avs_byteenable[1] && idx == `REG_INT_MASK) begin
        mask_q[NCH-1:8] <= avs_writedata[NCH-1:8];
      end
    end
  end

  // Sticky status: a new event wins over a write-one clear or clear bit.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (set_ev[i]) begin
          status_q[i] <= 1'b1;
        end else if (ctrl_q[`CTRL_INT_CLR]) begin
          status_q[i] <= 1'b0;
        end else if (wr_fire && idx == `REG_INT_STATUS &&
                     avs_byteenable[i / 8] && avs_writedata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl_q[`CTRL_INT_EN] && |(status_q & ~mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux. Values are read live, so no cycle boundary is awaited.
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < NCH; i++) begin
      if (idx == `REG_VALUE_BASE + 8'(i)) begin
        rd_word[7:0] = val_q[i];
      end
      if (idx == `REG_LIMIT_BASE + 8'(2 * i)) begin
        rd_word[7:0] = hi_q[i];
      end
      if (idx == `REG_LIMIT_BASE + 8'(2 * i + 1)) begin
        rd_word[7:0] = lo_q[i];
      end
    end
    if (idx == `REG_CTRL) begin
      rd_word[7:0] = ctrl_q;
    end
    if (idx == `REG_FUNC_SEL) begin
      rd_word[7:0] = func_q;
    end
    if (idx == `REG_TEMP_FRAC) begin
      rd_word[7:0] = {frac_q, frcfg_q};
    end
    if (idx == `REG_INT_STATUS) begin
      rd_word[NCH-1:0] = status_q;
    end
    if (idx == `REG_INT_MASK) begin
      rd_word[NCH-1:0] = mask_q;
    end
  end

  // Every access gets exactly one wait cycle; the bus sees a fixed latency.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (rd_fire) begin
        avs_readdata <= rd_word;
      end
    end
  end
endmodule

// ===== temp_monitor_sequencer_asserts.sv
// Purpose: Port checks of the monitor sequencer.
// Assumes: One clock domain.
// Notes: Slot spacing is checked as a lower bound only.
`timescale 1ns/10ps
`include "temp_monitor_consts.svh"
module temp_monitor_sequencer_chk #(
  parameter int unsigned ANALOG_SLOT_CYC = 20,
  parameter int unsigned SUB_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Converter, fan and interrupt
  input wire logic conv_start,
  input wire temp_monitor_pkg::chan_t conv_sel,
  input wire logic fan_mon_start,
  input wire logic fan_mon_run,
  input wire logic irq
);
  logic ctl_wr;
  logic rem;
  logic [31:0] gap_q;
  logic [4:0] pulses_q;
  logic [3:0] last_q;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
    avs_address[9:2] == `REG_CTRL;
  assign rem = last_q == `CH_REMOTE1 || last_q == `CH_REMOTE2;
  // Gap saturates so the first slot after reset is never too early.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_q <= 32'hFFFFFFFF;
      pulses_q <= 5'h00;
      last_q <= 4'h0;
    end else if (conv_start) begin
      gap_q <= 32'h0;
      last_q <= conv_sel;
      pulses_q <= (conv_sel == last_q) ? pulses_q + 5'h01 : 5'h01;
    end else if (!(&gap_q)) begin
      gap_q <= gap_q + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no bus answer");
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("long start");
  property p_sel_hold;
    conv_start |=> $stable(conv_sel) [*8];
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("sel moved");
  property p_gap;
    conv_start |-> gap_q >= (rem ? SUB_CYC - 1 : ANALOG_SLOT_CYC);
  endproperty
  a_gap: assert property (p_gap)
    else $error("slot too short");
  property p_remote16;
    conv_start && conv_sel != last_q && rem |-> pulses_q == 5'h10;
  endproperty
  a_remote16: assert property (p_remote16)
    else $error("not 16 samples");
  property p_irq_off;
    ctl_wr && !avs_writedata[`CTRL_INT_EN] |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq not gated");
  property p_fan_conv;
    fan_mon_start |-> ##[0:4] conv_start;
  endproperty
  a_fan_conv: assert property (p_fan_conv)
    else $error("fan start alone");
  property p_stop;
    ctl_wr && !avs_writedata[`CTRL_START] |-> ##[1:2] !fan_mon_run;
  endproperty
  a_stop: assert property (p_stop)
    else $error("run kept");
  property p_go;
    ctl_wr && avs_writedata[`CTRL_START] &&
      !avs_writedata[`CTRL_INT_CLR] |-> ##[1:3] fan_mon_run;
  endproperty
  a_go: assert property (p_go)
    else $error("run not begun");
  c_remote: cover property (conv_start && rem && pulses_q == 5'h10);
  c_irq: cover property ($rose(irq));
  c_stop: cover property ($fell(fan_mon_run));
endmodule
bind temp_monitor_sequencer temp_monitor_sequencer_chk #(
  .ANALOG_SLOT_CYC(ANALOG_SLOT_CYC),
  .SUB_CYC(SUB_CYC)
) u_temp_monitor_sequencer_chk (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .conv_start(conv_start),
  .conv_sel(conv_sel), .fan_mon_start(fan_mon_start),
  .fan_mon_run(fan_mon_run), .irq(irq)
);

// ===== temp_monitor_sequencer_test.sv
// Purpose: Self-checking bench of the monitor sequencer.
// Assumes: Shortened slot lengths.
// Notes: Reads and slot order are checked from queues.
`timescale 1ns/10ps
`include "temp_monitor_consts.svh"
module temp_monitor_sequencer_test;
  import temp_monitor_pkg::*;
  localparam int unsigned A = 20;
  localparam int unsigned T = 400;
  localparam int unsigned S = 20;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, conv_start, fan_mon_start, fan_mon_run, irq;
  chan_t conv_sel;
  chan_t last_sel = 4'hF;
  logic [9:0] conv_result;
  logic [7:0] base [0:8];
  logic [7:0] v;
  logic [31:0] q_rd [$];
  chan_t q_ord [$];
  int fails = 0;
  int checked = 0;
  int seed = 87647;
  int n;
  always #2.5 clk_sys = ~clk_sys;
  temp_monitor_sequencer #(.ANALOG_SLOT_CYC(A), .TEMP_SLOT_CYC(T),
    .SUB_CYC(S), .TW(24)) u_temp_monitor_sequencer (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_start(conv_start), .conv_sel(conv_sel),
    .conv_result(conv_result), .fan_mon_start(fan_mon_start),
    .fan_mon_run(fan_mon_run), .irq(irq));
  conv_front_model u_conv_front_model (.clk_sys(clk_sys), .rst(rst),
    .conv_start(conv_start), .conv_sel(conv_sel), .base(base),
    .conv_result(conv_result));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Entered just after a rising edge; request held until the answer.
  task automatic bus(input logic wr, input logic [7:0] idx,
      input logic [31:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    q_rd.push_back(exp);
    bus(1'b0, idx, 32'h0);
  endtask
  // Waits for the lowest channel's slot to begin, so the expected order is
  // never pushed in mid-round; returns as that channel's next slot begins.
  task automatic round(input logic [8:0] en);
    for (int c = 8; c >= 0; c--)
      if (en[c]) v = c[7:0];
    do @(posedge clk_sys);
    while (!(conv_start === 1'b1 && conv_sel === v[3:0]));
    @(posedge clk_sys);
    for (int c = 1; c < 9; c++)
      if (en[c] && en & ((9'h1 << c) - 9'h1)) q_ord.push_back(c[3:0]);
    q_ord.push_back(v[3:0]);
    while (q_ord.size() > 0) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0 && q_rd.size() > 0)
      check("readdata", avs_readdata, q_rd.pop_front());
    if (conv_start === 1'b1 && conv_sel !== last_sel) begin
      last_sel = conv_sel;
      if (q_ord.size() > 0)
        check("conv_sel", conv_sel, q_ord.pop_front());
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int c = 0; c < 9; c++)
      base[c] = $random(seed) % 100;
    base[2][0] = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b1, 8'h10, 32'h5A);
    rd(8'h10, 32'h0);
    rd(`REG_CTRL, 32'h0);
    rd(`REG_FUNC_SEL, 32'h0);
    rd(8'h2B, 32'hFF);
    rd(8'h2C, 32'h00);
    rd(8'h37, 32'h7F);
    rd(`REG_INT_TEMP, 32'h0);
    bus(1'b1, `REG_FUNC_SEL, 32'h07);
    bus(1'b1, `REG_INT_MASK, 32'h0);
    bus(1'b1, 8'h2F, {24'h0, base[2] - 8'h01});
    bus(1'b1, 8'h38, 32'h80);
    bus(1'b1, 8'h37, {24'h0, base[6] + 8'h06});
    q_ord.push_back(`CH_AIN1);
    bus(1'b1, `REG_CTRL, 32'h03);
    round(9'h1FF);
    for (int c = 0; c < 9; c++) begin
      v = base[c] + ((c == 6 || c == 8) ? 8'h07 : 8'h00);
      rd(8'h20 + c[7:0], {24'h0, v});
    end
    rd(`REG_TEMP_FRAC, 32'h80);
    rd(`REG_INT_STATUS, 32'h044);
    check("irq", irq, 1'b1);
    bus(1'b1, `REG_INT_MASK, 32'h1FF);
    repeat (2) @(posedge clk_sys);
    check("irq", irq, 1'b0);
    bus(1'b1, `REG_INT_MASK, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h01);
    repeat (2) @(posedge clk_sys);
    check("irq", irq, 1'b0);
    bus(1'b1, `REG_CTRL, 32'h03);
    // Hot limit lifted: the alarm must hold until the hysteresis limit.
    bus(1'b1, 8'h37, 32'h7F);
    bus(1'b1, 8'h2F, 32'hFF);
    bus(1'b1, `REG_INT_STATUS, 32'h1FF);
    round(9'h1FF);
    rd(`REG_INT_STATUS, 32'h040);
    bus(1'b1, 8'h38, 32'h7F);
    round(9'h1FF);
    bus(1'b1, `REG_INT_STATUS, 32'h1FF);
    round(9'h1FF);
    rd(`REG_INT_STATUS, 32'h000);
    check("irq", irq, 1'b0);
    bus(1'b1, `REG_CTRL, 32'h00);
    repeat (T + 20) @(posedge clk_sys);
    n = 0;
    repeat (2 * T) begin
      @(posedge clk_sys);
      if (conv_start !== 1'b0) n++;
    end
    check("conv_start count", n, 0);
    bus(1'b1, `REG_FUNC_SEL, 32'h00);
    q_ord.push_back(4'h2);
    bus(1'b1, `REG_CTRL, 32'h01);
    round(9'h0FC);
    end_sim();
  end
endmodule
